// file: hdl/prbs_pkg.sv
// package of constants for the processor reset and bus start-up block
package prbs_pkg;
   // state encoding of the start-up sequencer
   typedef enum logic [1:0] {
      PRBS_RESET = 2'b00,
      PRBS_QUIET = 2'b01,
      PRBS_FETCH = 2'b10,
      PRBS_RUN = 2'b11
   } prbs_state_e;
   localparam int ADDR_W = 30;
   localparam logic [ADDR_W-1:0] RESET_VECTOR = 30'h0000_0000;
   localparam logic [1:0] REPLY_IDLE = 2'h0;
   localparam logic [1:0] REPLY_WAIT = 2'h1;
   localparam logic [1:0] REPLY_OK = 2'h2;
   localparam logic [1:0] REPLY_FAULT = 2'h3;
   localparam logic [2:0] QUIET_CLOCKS = 3'h1;
   localparam int WARM_RESET_CYCLES = 8;
endpackage

// file: hdl/prbs_edge_sync.sv
// falling-edge capture of the reset and multiplier-enable inputs
`timescale 1ns/1ns
module prbs_edge_sync (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // raw inputs
   input wire logic rstRaw_n,
   input wire logic clock_multiplier_enable,
   // captured levels
   output logic rstSeen_n,
   output logic pllEnSeen
);
   logic rstNeg_q;
   logic enNeg_q;
   // sample on the falling edge, the shared reference edge
   always_ff @(negedge clk_sys) begin
      rstNeg_q <= rstRaw_n;
      enNeg_q <= clock_multiplier_enable;
   end
   // move to the rising domain
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rstSeen_n <= 1'b0;
         pllEnSeen <= 1'b0;
      end else begin
         rstSeen_n <= rstNeg_q;
         pllEnSeen <= enNeg_q;
      end
   end
endmodule

// file: hdl/prbs_startup.sv
// reset and bus start-up sequencer of the processor side bus
`timescale 1ns/1ns
// Overview of operation
// - while reset is held both address buses float; the error output and the lock pin stay driven
// - error output is driven low throughout reset
// - bus stays floated one clock after reset release is detected
// - first instruction fetch after reset reads address zero
// - no data-side access until the program requests one
// - warm reset leaves state the same as power-up reset, except pllEnSeen, which only rst clears
module prbs_startup (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // pins from the outside party
   input wire logic reset_n,
   input wire logic clock_multiplier_enable,
   // core requests
   input wire logic instReq,
   input wire logic [prbs_pkg::ADDR_W-1:0] instAddr,
   input wire logic dataReq,
   input wire logic [prbs_pkg::ADDR_W-1:0] dataAddr,
   input wire logic dataWrite,
   input wire logic dataLock,
   input wire logic errIn,
   // replies from responders
   input wire logic [1:0] instReply,
   input wire logic [1:0] data_reply,
   // instruction bus pins
   output logic [prbs_pkg::ADDR_W-1:0] instAddrOut,
   output logic instAddrOe,
   output logic instStrobe,
   // data bus pins
   output logic [prbs_pkg::ADDR_W-1:0] data_word_address,
   output logic dataAddrOe,
   output logic dataStrobe,
   output logic dataRdWr,
   output logic atomic_bus_hold_n,
   // error output and status
   output logic errOut,
   output logic errOe,
   output logic coreRunning
);
   logic rstSeen_n;
   logic pllEnSeen;
   logic coreRst;
   prbs_pkg::prbs_state_e state_q;
   logic [2:0] quietCnt_q;
   logic instBusy_q;
   logic dataBusy_q;

   // -----------------------------------------------------------
   // reset capture
   // -----------------------------------------------------------
   // falling-edge capture
   prbs_edge_sync uSync (
      .clk_sys(clk_sys),
      .rst(rst),
      .rstRaw_n(reset_n),
      .clock_multiplier_enable(clock_multiplier_enable),
      .rstSeen_n(rstSeen_n),
      .pllEnSeen(pllEnSeen)
   );
   // warm and cold share one path
   // either source alone resets every register outside uSync, so a warm reset leaves
   // the same state there as a cold one; pllEnSeen in uSync is cleared only by rst
   assign coreRst = rst | ~rstSeen_n;

   // -----------------------------------------------------------
   // start-up sequencer
   // -----------------------------------------------------------
   // state walk: reset, quiet, first fetch, run
   always_ff @(posedge clk_sys) begin
      if (coreRst) begin
         state_q <= prbs_pkg::PRBS_RESET;
         quietCnt_q <= 3'h0;
      end else begin
         case (state_q)
            prbs_pkg::PRBS_RESET: begin
               state_q <= prbs_pkg::PRBS_QUIET;
               quietCnt_q <= 3'h0;
            end
            prbs_pkg::PRBS_QUIET: begin
               quietCnt_q <= quietCnt_q + 3'h1;
               if (quietCnt_q + 3'h1 >= prbs_pkg::QUIET_CLOCKS) begin
                  state_q <= prbs_pkg::PRBS_FETCH;
               end
            end
            prbs_pkg::PRBS_FETCH: begin
               // hold here until the vector fetch is answered, so that no
               // core request can overtake the first fetch
               if (instReply == prbs_pkg::REPLY_OK || instReply == prbs_pkg::REPLY_FAULT) begin
                  state_q <= prbs_pkg::PRBS_RUN;
               end
            end
            default: begin
               state_q <= prbs_pkg::PRBS_RUN;
            end
         endcase
      end
   end

   // -----------------------------------------------------------
   // instruction bus
   // -----------------------------------------------------------
   // drives and first fetch
   always_ff @(posedge clk_sys) begin
      if (coreRst) begin
         instAddrOe <= 1'b0;
         instStrobe <= 1'b0;
         instAddrOut <= prbs_pkg::RESET_VECTOR;
         instBusy_q <= 1'b0;
      end else if (state_q == prbs_pkg::PRBS_QUIET) begin
         if (quietCnt_q + 3'h1 >= prbs_pkg::QUIET_CLOCKS) begin
            instAddrOe <= 1'b1;
            instStrobe <= 1'b1;
            instAddrOut <= prbs_pkg::RESET_VECTOR;
            instBusy_q <= 1'b1;
         end
      end else if (state_q == prbs_pkg::PRBS_FETCH) begin
         instStrobe <= 1'b0;
      end else if (state_q == prbs_pkg::PRBS_RUN) begin
         instAddrOe <= 1'b1;
         instStrobe <= instReq;
         if (instReq) begin
            instAddrOut <= instAddr;
         end
         instBusy_q <= instReq;
      end
   end

   // -----------------------------------------------------------
   // data bus
   // -----------------------------------------------------------
   // data side only on explicit request
   always_ff @(posedge clk_sys) begin
      if (coreRst) begin
         dataAddrOe <= 1'b0;
         dataStrobe <= 1'b0;
         dataRdWr <= 1'b0;
         // lock pin has no enable, so keep it negated while in reset
         atomic_bus_hold_n <= 1'b1;
         data_word_address <= prbs_pkg::RESET_VECTOR;
         dataBusy_q <= 1'b0;
      end else if (state_q == prbs_pkg::PRBS_RUN) begin
         dataAddrOe <= 1'b1;
         atomic_bus_hold_n <= ~dataLock;
         dataStrobe <= dataReq;
         if (dataReq) begin
            data_word_address <= dataAddr;
            dataRdWr <= ~dataWrite;
         end
         dataBusy_q <= dataReq | (dataBusy_q & data_reply == prbs_pkg::REPLY_WAIT);
      end else begin
         dataStrobe <= 1'b0;
      end
   end

   // -----------------------------------------------------------
   // error output and status
   // -----------------------------------------------------------
   // error driven low in reset
   // the error pin is never floated, so its enable stays high throughout
   always_ff @(posedge clk_sys) begin
      if (coreRst) begin
         errOut <= 1'b0;
         errOe <= 1'b1;
         coreRunning <= 1'b0;
      end else begin
         errOut <= errIn & pllEnSeen;
         errOe <= 1'b1;
         coreRunning <= (state_q == prbs_pkg::PRBS_RUN);
      end
   end

   // -----------------------------------------------------------
   // checks
   // -----------------------------------------------------------
   AST_FLOAT_IN_RESET: assert property (@(posedge clk_sys)
      $past(coreRst) |-> !instAddrOe && !dataAddrOe && !instStrobe)
      else $error("bus driven during reset");
   AST_ERR_LOW: assert property (@(posedge clk_sys)
      $past(coreRst) |-> errOe && !errOut)
      else $error("error output not driven low in reset");
   AST_QUIET_CLOCK: assert property (@(posedge clk_sys) disable iff (coreRst)
      (state_q == prbs_pkg::PRBS_QUIET && $past(state_q) == prbs_pkg::PRBS_RESET)
      |-> !instAddrOe && !instStrobe ##1 instStrobe)
      else $error("quiet clock not kept");
   AST_FIRST_FETCH: assert property (@(posedge clk_sys) disable iff (coreRst)
      (state_q == prbs_pkg::PRBS_FETCH && $rose(instStrobe))
      |-> instAddrOut == prbs_pkg::RESET_VECTOR)
      else $error("first fetch not at zero");
   AST_NO_DATA: assert property (@(posedge clk_sys) disable iff (rst)
      dataStrobe |-> $past(dataReq) && $past(state_q) == prbs_pkg::PRBS_RUN)
      else $error("data access without request");
   AST_WARM_SAME: assert property (@(posedge clk_sys)
      $fell(coreRst) |-> state_q == prbs_pkg::PRBS_RESET && quietCnt_q == 3'h0)
      else $error("state differs after reset");
   AST_FALL_EDGE: assert property (@(posedge clk_sys) disable iff (rst)
      !rstSeen_n |=> state_q == prbs_pkg::PRBS_RESET)
      else $error("left reset before falling edge release");
   AST_LOCK_FWD: assert property (@(posedge clk_sys) disable iff (coreRst)
      (state_q == prbs_pkg::PRBS_RUN && $past(state_q) == prbs_pkg::PRBS_RUN)
      |-> atomic_bus_hold_n == !$past(dataLock))
      else $error("lock not driven");
endmodule

// file: sim/prbs_responder.sv
// responder model answering one side of the processor bus
`timescale 1ns/1ns
module prbs_responder (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // processor side
   input wire logic strobe,
   input wire logic [29:0] addr,
   input wire logic lockIn_n,
   output logic [1:0] reply,
   // bench control and memory side
   input wire logic [1:0] waits,
   input wire logic faultReq,
   output logic lockOut_n,
   output logic [29:0] heldAddr
);
   logic busyQ;
   logic skipQ;
   logic quietQ;
   logic [1:0] cntQ;
   // ----------------------------------------
   // reply engine
   // ----------------------------------------
   // ignore, latch, reply
   always_ff @(posedge clk_sys) begin
      quietQ <= rst;
      lockOut_n <= lockIn_n;
      reply <= prbs_pkg::REPLY_IDLE;
      if (rst) begin
         busyQ <= 1'b0;
         skipQ <= 1'b0;
      end else if (busyQ) begin
         cntQ <= cntQ - 2'h1;
         busyQ <= (cntQ != 2'h0);
         skipQ <= (cntQ == 2'h0) && faultReq;
         if (cntQ != 2'h0) reply <= prbs_pkg::REPLY_WAIT;
         else reply <= faultReq ? prbs_pkg::REPLY_FAULT : prbs_pkg::REPLY_OK;
      end else if (strobe && !quietQ) begin
         skipQ <= 1'b0;
         busyQ <= !skipQ;
         heldAddr <= addr;
         cntQ <= waits;
      end
   end
endmodule

// file: sim/prbs_startup_bench.sv
// self-checking bench of the processor reset and bus start-up block
`timescale 1ns/1ns
module prbs_startup_bench;
   logic clk_sys, rst, reset_n, clock_multiplier_enable, instReq, dataReq, dataWrite;
   logic dataLock, errIn, instAddrOe, instStrobe, dataAddrOe, dataStrobe, dataRdWr;
   logic atomic_bus_hold_n, errOut, errOe, coreRunning, fault, mon;
   logic [29:0] instAddr, dataAddr, instAddrOut, data_word_address;
   logic [1:0] instReply, data_reply, waits;
   logic [31:0] instQ[$];
   logic [31:0] dataQ[$];
   int failures, total_checks, n;
   // clock generation
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   prbs_startup prbs_startup_inst (.clk_sys, .rst, .reset_n, .clock_multiplier_enable,
      .instReq, .instAddr, .dataReq, .dataAddr, .dataWrite, .dataLock, .errIn, .instReply,
      .data_reply, .instAddrOut, .instAddrOe, .instStrobe, .data_word_address, .dataAddrOe,
      .dataStrobe, .dataRdWr, .atomic_bus_hold_n, .errOut, .errOe, .coreRunning);
   prbs_responder prbs_responder_inst (.clk_sys, .rst(~reset_n), .strobe(instStrobe),
      .addr(instAddrOut), .lockIn_n(1'b1), .reply(instReply), .waits, .faultReq(1'b0),
      .lockOut_n(), .heldAddr());
   prbs_responder prbs_responder_data_inst (.clk_sys, .rst(~reset_n), .strobe(dataStrobe),
      .addr(data_word_address), .lockIn_n(atomic_bus_hold_n), .reply(data_reply), .waits,
      .faultReq(fault), .lockOut_n(), .heldAddr());
   // ----------------------------------------
   // checking helpers
   // ----------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task print_verdict;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // reset, then watch the quiet clock and the first fetch
   task do_reset(input int hold, input logic pwr);
      int k;
      mon = 1'b0;
      instQ.delete();
      dataQ.delete();
      rst <= pwr;
      reset_n <= 1'b0;
      repeat (hold) @(negedge clk_sys);
      chk({instAddrOe, dataAddrOe, instStrobe, dataStrobe}, 0); // outputs float
      chk({errOe, errOut}, 2'b10); // error driven low
      chk(atomic_bus_hold_n, 1); // lock pin negated
      rst <= 1'b0;
      reset_n <= 1'b1;
      k = 0;
      while (instStrobe !== 1'b1 && k < 10) begin
         @(negedge clk_sys);
         k++;
         if (instStrobe !== 1'b1) chk({instAddrOe, dataAddrOe, dataStrobe}, 0);
      end
      if (k == 10) failures++;
      if (k == 10) print_verdict();
      chk(k >= 2, 1); // quiet clock counted
      chk({2'h0, instAddrOut}, {2'h0, prbs_pkg::RESET_VECTOR}); // vector fetch
      k = 0;
      while (coreRunning !== 1'b1 && k < 20) begin
         @(negedge clk_sys);
         k++;
      end
      chk(coreRunning, 1); // same start-up
      if (k == 20) print_verdict();
      mon = 1'b1;
   endtask
   // random fetch and data requests against the queue model
   task traffic;
      logic [31:0] r;
      repeat (40) begin
         @(negedge clk_sys);
         r = $urandom;
         instReq <= r[0];
         instAddr <= r[31:2];
         if (r[0]) instQ.push_back({2'h0, r[31:2]});
         waits <= r[5:4];
         r = $urandom;
         dataReq <= r[0];
         dataWrite <= r[1];
         dataLock <= r[2];
         dataAddr <= r[31:2];
         fault <= (r[8:6] == 3'h0);
         errIn <= r[9];
         if (r[0]) dataQ.push_back({1'b0, ~r[1], r[31:2]});
      end
      @(negedge clk_sys);
      instReq <= 1'b0;
      dataReq <= 1'b0;
      @(negedge clk_sys);
   endtask
   // compare strobed requests and the lock pin at every falling edge
   always @(negedge clk_sys) begin
      if (mon) begin
         if (instStrobe === 1'b1) chk({2'h0, instAddrOut}, instQ.pop_front());
         if (dataStrobe === 1'b1) begin
            chk({1'b0, dataRdWr, data_word_address}, dataQ.pop_front());
         end
         chk(atomic_bus_hold_n, {31'h0, ~dataLock});
         chk({instAddrOe, dataAddrOe, errOe}, 3'h7);
         chk(errOut, errIn & clock_multiplier_enable);
      end
   end
   // main sequence: power-up, warm reset of eight clocks, power-up again
   initial begin
      failures = 0;
      total_checks = 0;
      mon = 1'b0;
      rst = 1'b1;
      reset_n = 1'b0;
      clock_multiplier_enable = 1'b1; // held stable
      {instReq, dataReq, dataWrite, dataLock, errIn, fault} = 6'h00;
      {instAddr, dataAddr, waits} = 62'h0;
      void'($urandom(32'h354712d5));
      @(negedge clk_sys);
      for (n = 0; n < 3; n++) begin
         do_reset(n == 1 ? 8 : 20, n != 1); // reset kinds
         traffic(); // data only on request
      end
      print_verdict();
   end
endmodule
